// File: rtl/serial_port_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// =====================================================================
// Register word indices (byte address is four times the index)
`define IDX_DATA        3'h0
`define IDX_STATUS      3'h1
`define IDX_IRQ_LEVEL   3'h3
`define IDX_LINE_ENABLE 3'h4
`define IDX_FORMAT      3'h5
`define IDX_BAUD_LOW    3'h6
`define IDX_BAUD_HIGH   3'h7

// =====================================================================
// Line enable fields
`define LE_RX_ON        4
`define LE_TX_ON        3
`define LE_DOUBLE       2
`define LE_ADDR_FILTER  1
`define LE_TX_NINTH     0
`define LE_WIDTH        5

// =====================================================================
// Frame format fields
`define FMT_MODE_HI     7
`define FMT_MODE_LO     6
`define FMT_PAR_HI      5
`define FMT_PAR_LO      4
`define FMT_STOP        3
`define FMT_SIZE_HI     2
`define FMT_SIZE_LO     0
`define FMT_ORDER       2
`define FMT_PHASE       1

// =====================================================================
// Status fields
`define ST_RX_DONE      7
`define ST_TX_DONE      6
`define ST_TX_EMPTY     5
`define ST_FRAME_ERR    4
`define ST_OVERFLOW     3
`define ST_PARITY_ERR   2
`define ST_RX_NINTH     0

// =====================================================================
// Encodings
`define MODE_ASYNC      2'b00
`define MODE_SYNC       2'b01
`define MODE_INFRARED   2'b10
`define MODE_SPI        2'b11
`define PAR_OFF         2'b00
`define PAR_EVEN        2'b10
`define PAR_ODD         2'b11
`define SIZE_NINE       3'b111
`define SIZE_BASE       4'h5
`define SCALE_RESERVED  4'h8

// =====================================================================
// Reset values and timing counts (baud ticks per bit)
`define RST_BYTE        8'h00
`define TICKS_NORMAL    5'h10
`define TICKS_DOUBLE    5'h08
`define TICKS_CLOCKED   5'h02

// =====================================================================
// Interrupt vector word offsets
`define VEC_RX_DONE     8'h00
`define VEC_TX_EMPTY    8'h02
`define VEC_TX_DONE     8'h04

`endif

// File: rtl/serial_port_pkg.sv
// Types shared by the serial port design files
package serial_port_pkg;

	typedef enum logic {
		RX_IDLE,
		RX_FRAME
	} rx_state_t;

	typedef logic [11:0] divisor_t;

endpackage : serial_port_pkg

// File: rtl/baud_tick_gen.sv
// Baud prescaler producing one tick per scaled divisor period
`timescale 1ns/100ps
`include "serial_port_regs.svh"

module baud_tick_gen
	import serial_port_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     resetn,
	input  wire divisor_t divisor,
	input  wire logic [3:0] scale,
	input  wire logic     reload,
	output logic          tick_reg
);

	logic [19:0] count_reg;
	wire  [2:0]  shift_amt;
	wire  [19:0] period;
	wire  [19:0] period_m1;
	wire         wrap;

	// Negative and reserved scales run at unity; fractional steps are not modelled
	assign shift_amt = scale[3] ? 3'h0 : scale[2:0]; // see RULE19
	assign period    = ({8'h00, divisor} + 20'h0_0001) << shift_amt; // see RULE24
	assign period_m1 = period - 20'h0_0001;
	assign wrap      = (count_reg >= period_m1);

	always_ff @(posedge clk) begin
		if (!resetn || reload) begin // see RULE17
			count_reg <= 20'h0_0000;
			tick_reg  <= 1'b0;
		end else begin
			count_reg <= wrap ? 20'h0_0000 : count_reg + 20'h0_0001;
			tick_reg  <= wrap;
		end
	end

endmodule : baud_tick_gen

// File: rtl/serial_port_control_and_baud.sv
// Serial port with frame format, line control, SPI master and baud divisor
//
// Summary of operation
// RULE1: Receiver enable starts receiver, takes receive pin
// RULE2: Receiver disable flushes buffer and its error flags
// RULE3: Transmitter enable starts transmitter, takes transmit pin
// RULE4: Transmitter drains pending data before releasing pin
// RULE5: Double speed halves oversampling, asynchronous modes only
// RULE6: Software keeps double speed off in infrared/synchronous
// RULE7: Address filter drops frames without address mark
// RULE8: Ninth transmit bit sent; software writes it first
// RULE9: Mode field selects async, sync, infrared, SPI
// RULE10: Parity field: off, even, odd; 01 reserved
// RULE11: Parity appended on transmit, checked on receive
// RULE12: Stop select gives one or two transmit stops
// RULE13: Size field gives five to nine shared bits
// RULE14: SPI bit order selects lsb or msb first
// RULE15: SPI phase selects leading or trailing sampling
// RULE16: Twelve-bit divisor split over low, high registers
// RULE17: Low divisor write reloads the prescaler at once
// RULE18: Software leaves baud alone while lines active
// RULE19: Scale field is signed four bit, 1000 reserved
// RULE20: Vectors at 0x00, 0x02, 0x04 word offsets
// RULE21: Software writes zero to reserved bits
// RULE22: SPI ignores async options, reports three flags
// RULE23: Buffer empty flag set at reset, gates writes
// RULE24: Bit period derived from divisor and scale
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "serial_port_regs.svh"

module serial_port_control_and_baud
	import serial_port_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rxd_in,
	output logic             txd_out,
	output logic             txd_oe,
	output logic             rxd_takeover,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	output logic             irq_pending,
	output logic      [7:0]  irq_vector
);

	// =====================================================================
	// Helpers
	function automatic logic [3:0] char_bits(input logic [2:0] size, input logic spi);
		if (spi)
			char_bits = 4'h8;
		else if (size == `SIZE_NINE)
			char_bits = 4'h9;
		else
			char_bits = `SIZE_BASE + {2'b00, size[1:0]}; // see RULE13
	endfunction : char_bits

	function automatic logic [8:0] bit_mask(input logic [3:0] n);
		logic [8:0] m;
		m = 9'h000;
		for (int i = 0; i < 9; i++)
			m[i] = (i < n);
		bit_mask = m;
	endfunction : bit_mask

	function automatic logic [7:0] reverse8(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = d[7 - i];
		reverse8 = r;
	endfunction : reverse8

	// =====================================================================
	// State
	logic [5:0]          irq_level_reg;
	logic [`LE_WIDTH-1:0] line_en_reg;
	logic [7:0]          format_reg;
	logic [7:0]          baud_low_reg;
	logic [7:0]          baud_high_reg;
	logic [8:0]          tx_buf_reg;
	logic                tx_buf_full_reg;
	logic [12:0]         tx_shift_reg;
	logic [3:0]          tx_left_reg;
	logic [4:0]          tx_cnt_reg;
	logic                tx_busy_reg;
	logic                tx_done_flag_reg;
	rx_state_t           rx_state_reg;
	logic [4:0]          rx_cnt_reg;
	logic [3:0]          rx_idx_reg;
	logic [9:0]          rx_sh_reg;
	logic [11:0]         rx_fifo_reg [0:1];
	logic [1:0]          rx_count_reg;
	logic                baud_tick;

	// =====================================================================
	// Control decode
	wire       receiver_on         = line_en_reg[`LE_RX_ON];
	wire       transmitter_on      = line_en_reg[`LE_TX_ON];
	wire       double_speed        = line_en_reg[`LE_DOUBLE];
	wire       address_filter_mode = line_en_reg[`LE_ADDR_FILTER];
	wire       tx_ninth_bit        = line_en_reg[`LE_TX_NINTH];
	wire [1:0] comm_mode_sel       = format_reg[`FMT_MODE_HI:`FMT_MODE_LO];
	wire [1:0] parity_sel          = format_reg[`FMT_PAR_HI:`FMT_PAR_LO];
	wire       stop_count_sel      = format_reg[`FMT_STOP];
	wire [2:0] char_width_sel      = format_reg[`FMT_SIZE_HI:`FMT_SIZE_LO];
	wire       bit_order_sel       = format_reg[`FMT_ORDER];
	wire       sample_edge_sel     = format_reg[`FMT_PHASE];
	wire [3:0] baud_scale          = baud_high_reg[7:4];
	wire divisor_t baud_divisor    = {baud_high_reg[3:0], baud_low_reg}; // see RULE16

	wire spi_master_mode = (comm_mode_sel == `MODE_SPI); // see RULE9
	wire sync_mode       = (comm_mode_sel == `MODE_SYNC);
	wire clocked_mode    = spi_master_mode | sync_mode;
	wire infrared_mode   = (comm_mode_sel == `MODE_INFRARED);
	wire async_like      = (comm_mode_sel == `MODE_ASYNC) | infrared_mode;

	// Double speed only touches the asynchronous oversampling
	wire [4:0] ticks_per_bit = clocked_mode ? `TICKS_CLOCKED :
		((double_speed & async_like) ? `TICKS_DOUBLE : `TICKS_NORMAL); // see RULE5
	wire [4:0] ticks_m1   = ticks_per_bit - 5'h01;
	wire [4:0] ticks_mid  = (ticks_per_bit >> 1) - 5'h01;

	wire       parity_on  = !spi_master_mode & parity_sel[1]; // see RULE10
	wire       parity_odd = (parity_sel == `PAR_ODD);
	wire       use_filter = address_filter_mode & !spi_master_mode; // see RULE22
	wire       two_stops  = stop_count_sel & !spi_master_mode; // see RULE12
	wire [3:0] nbits      = char_bits(char_width_sel, spi_master_mode);
	wire [8:0] nmask      = bit_mask(nbits);

	// =====================================================================
	// Bus decode
	wire       bus_req    = avs_read | avs_write;
	wire       bus_first  = bus_req & avs_waitrequest;
	wire       wr_commit  = avs_write & !avs_waitrequest;
	wire       rd_commit  = avs_read & !avs_waitrequest;
	wire [7:0] wdata      = avs_writedata[7:0];
	wire       wr_data    = wr_commit & (avs_address == `IDX_DATA);
	wire       wr_status  = wr_commit & (avs_address == `IDX_STATUS);
	wire       wr_baud_lo = wr_commit & (avs_address == `IDX_BAUD_LOW);
	wire       rx_pop     = rd_commit & (avs_address == `IDX_DATA) & (rx_count_reg != 2'h0);

	// =====================================================================
	// Transmit framing
	wire [8:0] tx_data_m  = tx_buf_reg & nmask;
	wire       tx_parity  = (^tx_data_m) ^ parity_odd;
	wire [3:0] tx_len     = spi_master_mode ? 4'h8 :
		4'h2 + nbits + {3'h0, parity_on} + {3'h0, two_stops};
	logic [12:0] tx_frame;

	always_comb begin
		tx_frame = 13'h1_FFF;
		if (spi_master_mode) begin
			// Shift register always drains from bit 0, so order the byte here
			tx_frame[7:0] = bit_order_sel ? tx_buf_reg[7:0] : reverse8(tx_buf_reg[7:0]); // see RULE14
		end else begin
			tx_frame[0] = 1'b0;
			for (int i = 0; i < 9; i++)
				if (i < nbits)
					tx_frame[1 + i] = tx_buf_reg[i]; // see RULE8
			if (parity_on)
				tx_frame[1 + nbits] = tx_parity; // see RULE11
		end
	end

	wire tx_start   = !tx_busy_reg & tx_buf_full_reg & (transmitter_on | txd_oe);
	wire tx_bit_end = tx_busy_reg & baud_tick & (tx_cnt_reg == ticks_m1);
	wire tx_last    = tx_bit_end & (tx_left_reg == 4'h1);
	// SPI samples at the close of each bit; phase moves the clock level
	wire spi_sample = spi_master_mode & tx_busy_reg & baud_tick & (tx_cnt_reg == 5'h01); // see RULE15
	wire [3:0] spi_idx  = 4'h8 - tx_left_reg;
	wire [3:0] spi_pos  = bit_order_sel ? spi_idx : 4'h7 - spi_idx;
	wire sclk_next  = tx_busy_reg & clocked_mode &
		((tx_cnt_reg == 5'h01) ^ (spi_master_mode & sample_edge_sel)); // see RULE15

	// Accepted only while empty; later writes are dropped silently
	wire tx_accept  = wr_data & !tx_buf_full_reg; // see RULE23

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_buf_reg      <= 9'h000;
			tx_buf_full_reg <= 1'b0;
		end else if (tx_accept) begin
			tx_buf_reg      <= {tx_ninth_bit, wdata}; // see RULE8
			tx_buf_full_reg <= 1'b1;
		end else if (tx_start) begin
			tx_buf_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 13'h1_FFF;
			tx_left_reg  <= 4'h0;
			tx_cnt_reg   <= 5'h00;
		end else if (tx_start) begin
			tx_busy_reg  <= 1'b1;
			tx_shift_reg <= tx_frame;
			tx_left_reg  <= tx_len;
			tx_cnt_reg   <= 5'h00;
		end else if (tx_bit_end) begin
			tx_cnt_reg   <= 5'h00;
			tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
			tx_left_reg  <= tx_left_reg - 4'h1;
			tx_busy_reg  <= !tx_last;
		end else if (tx_busy_reg & baud_tick) begin
			tx_cnt_reg   <= tx_cnt_reg + 5'h01;
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn)
			tx_done_flag_reg <= 1'b0;
		else if (tx_last & !tx_buf_full_reg)
			tx_done_flag_reg <= 1'b1;
		else if (wr_status & wdata[`ST_TX_DONE])
			tx_done_flag_reg <= 1'b0;
	end

	// =====================================================================
	// Pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			txd_out          <= 1'b1;
			txd_oe           <= 1'b0;
			rxd_takeover     <= 1'b0;
			serial_clock_out <= 1'b0;
			serial_clock_oe  <= 1'b0;
		end else begin
			txd_out          <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
			txd_oe           <= transmitter_on |
				(txd_oe & (tx_busy_reg | tx_buf_full_reg)); // see RULE3 see RULE4
			rxd_takeover     <= receiver_on; // see RULE1
			serial_clock_out <= sclk_next;
			serial_clock_oe  <= clocked_mode & (transmitter_on | receiver_on);
		end
	end

	// =====================================================================
	// Receive framing
	wire       rx_sample  = (rx_state_reg == RX_FRAME) & baud_tick & (rx_cnt_reg == ticks_mid);
	wire [3:0] rx_stop_at = nbits + {3'h0, parity_on} + 4'h1;
	wire       rx_false   = rx_sample & (rx_idx_reg == 4'h0) & rxd_in;
	wire       rx_end     = rx_sample & (rx_idx_reg == rx_stop_at);
	wire       rx_store   = rx_sample & (rx_idx_reg != 4'h0) & (rx_idx_reg < rx_stop_at);
	wire [3:0] rx_wr_pos  = spi_sample ? spi_pos : rx_idx_reg - 4'h1;
	wire [8:0] rx_data_m  = rx_sh_reg[8:0] & nmask; // see RULE13
	wire       rx_par_bit = rx_sh_reg[nbits];
	wire       rx_parity_error_flag    = parity_on & (rx_par_bit != ((^rx_data_m) ^ parity_odd)); // see RULE11
	wire       rx_mark    = (nbits == 4'h9) ? rx_sh_reg[8] : rx_sh_reg[nbits - 4'h1];
	wire       rx_keep    = !use_filter | rx_mark; // see RULE7
	wire       rx_ninth   = (nbits == 4'h9) & rx_sh_reg[8];
	wire       spi_push   = spi_master_mode & tx_last & receiver_on;
	wire       async_push = !spi_master_mode & rx_end & rx_keep;
	wire       rx_push    = spi_push | async_push;
	// Entry layout: overflow, parity error, frame error, ninth bit, data
	wire [11:0] push_word = !spi_master_mode ? {1'b0, rx_parity_error_flag, !rxd_in, rx_ninth, rx_data_m[7:0]} :
		{4'h0, bit_order_sel ? {rxd_in, rx_sh_reg[6:0]} : {rx_sh_reg[7:1], rxd_in}};

	always_ff @(posedge clk) begin
		if (!resetn || !receiver_on) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= 5'h00;
			rx_idx_reg   <= 4'h0;
		end else begin
			case (rx_state_reg)
				RX_IDLE: begin
					if (baud_tick & !rxd_in & !spi_master_mode) begin
						rx_state_reg <= RX_FRAME;
						rx_cnt_reg   <= 5'h00;
						rx_idx_reg   <= 4'h0;
					end
				end
				RX_FRAME: begin
					if (rx_false | rx_end)
						rx_state_reg <= RX_IDLE;
					else if (baud_tick & (rx_cnt_reg == ticks_m1)) begin
						rx_cnt_reg <= 5'h00;
						rx_idx_reg <= rx_idx_reg + 4'h1;
					end else if (baud_tick)
						rx_cnt_reg <= rx_cnt_reg + 5'h01;
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			rx_sh_reg <= 10'h000;
		else if (rx_store | spi_sample)
			rx_sh_reg[rx_wr_pos] <= rxd_in;
	end

	// =====================================================================
	// Two-entry receive buffer, head in slot 0
	always_ff @(posedge clk) begin
		if (!resetn || !receiver_on) begin // see RULE2
			rx_count_reg   <= 2'h0;
			rx_fifo_reg[0] <= 12'h000;
			rx_fifo_reg[1] <= 12'h000;
		end else if (rx_push & rx_pop) begin
			if (rx_count_reg == 2'h1)
				rx_fifo_reg[0] <= push_word;
			else begin
				rx_fifo_reg[0] <= rx_fifo_reg[1];
				rx_fifo_reg[1] <= push_word;
			end
		end else if (rx_push) begin
			if (rx_count_reg == 2'h2)
				rx_fifo_reg[1][11] <= 1'b1;
			else begin
				rx_fifo_reg[rx_count_reg[0]] <= push_word;
				rx_count_reg <= rx_count_reg + 2'h1;
			end
		end else if (rx_pop) begin
			rx_fifo_reg[0] <= rx_fifo_reg[1];
			rx_count_reg   <= rx_count_reg - 2'h1;
		end
	end

	// =====================================================================
	// Registers and bus slave
	wire [11:0] rx_head    = rx_fifo_reg[0];
	wire        rx_ready   = (rx_count_reg != 2'h0);
	wire [7:0]  status_all = {rx_ready, tx_done_flag_reg, !tx_buf_full_reg,
		rx_head[9], rx_head[11], rx_head[10], 1'b0, rx_head[8]}; // see RULE23
	wire [7:0]  status_rd  = spi_master_mode ? {status_all[7:5], 5'h00} : status_all; // see RULE22
	logic [7:0] read_mux;

	always_comb begin
		case (avs_address)
			`IDX_DATA:        read_mux = rx_head[7:0];
			`IDX_STATUS:      read_mux = status_rd;
			`IDX_IRQ_LEVEL:   read_mux = {2'b00, irq_level_reg};
			`IDX_LINE_ENABLE: read_mux = {3'b000, line_en_reg};
			`IDX_FORMAT:      read_mux = format_reg;
			`IDX_BAUD_LOW:    read_mux = baud_low_reg;
			`IDX_BAUD_HIGH:   read_mux = baud_high_reg;
			default:          read_mux = `RST_BYTE;
		endcase
	end

	// One wait state: answer in the cycle after the request appears
	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !bus_first;
			if (bus_first)
				avs_readdata <= {24'h00_0000, read_mux};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_level_reg <= 6'h00;
			line_en_reg   <= 5'h00;
			format_reg    <= `RST_BYTE;
			baud_low_reg  <= `RST_BYTE;
			baud_high_reg <= `RST_BYTE;
		end else if (wr_commit) begin
			case (avs_address)
				`IDX_IRQ_LEVEL:   irq_level_reg <= wdata[5:0];
				`IDX_LINE_ENABLE: line_en_reg   <= wdata[`LE_WIDTH-1:0];
				`IDX_FORMAT:      format_reg    <= wdata;
				`IDX_BAUD_LOW:    baud_low_reg  <= wdata;
				`IDX_BAUD_HIGH:   baud_high_reg <= wdata;
				default:          ;
			endcase
		end
	end

	// =====================================================================
	// Vector request: receive, then buffer empty, then transmit done
	wire rx_irq  = rx_ready & (irq_level_reg[5:4] != 2'b00);
	wire dre_irq = !tx_buf_full_reg & (irq_level_reg[1:0] != 2'b00);
	wire txc_irq = tx_done_flag_reg & (irq_level_reg[3:2] != 2'b00);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_pending <= 1'b0;
			irq_vector  <= `VEC_RX_DONE;
		end else begin
			irq_pending <= rx_irq | dre_irq | txc_irq;
			irq_vector  <= rx_irq ? `VEC_RX_DONE :
				(dre_irq ? `VEC_TX_EMPTY : `VEC_TX_DONE); // see RULE20
		end
	end

	baud_tick_gen u_baud (
		.clk      (clk),
		.resetn   (resetn),
		.divisor  (baud_divisor),
		.scale    (baud_scale),
		.reload   (wr_baud_lo), // see RULE17
		.tick_reg (baud_tick)
	);

endmodule : serial_port_control_and_baud

// File: tb/serial_port_control_and_baud_asserts.sv
// Port-level checker for the serial port, attached by bind
`timescale 1ns/100ps

module serial_port_control_and_baud_asserts (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        rxd_in,
	input wire logic        txd_out,
	input wire logic        txd_oe,
	input wire logic        rxd_takeover,
	input wire logic        serial_clock_out,
	input wire logic        serial_clock_oe,
	input wire logic        irq_pending,
	input wire logic [7:0]  irq_vector
);
	// ==================================================================
	// Bus handshake
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_reset_state: assert property (disable iff (1'b0) !resetn |=> avs_waitrequest && txd_out
		&& !txd_oe && !rxd_takeover && !irq_pending) else $error("bad reset state");
	chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##1
		!avs_waitrequest) else $error("request not answered");
	chk_wait_has_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("answer without request");
	chk_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 3'h2
		|-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	// ==================================================================
	// Pin ownership and vectors
	chk_rx_takeover: assert property (avs_write && !avs_waitrequest && avs_address == 3'h4
		|-> ##2 rxd_takeover == $past(avs_writedata[4], 2)) else $error("rx pin ownership");
	chk_tx_takeover: assert property (avs_write && !avs_waitrequest && avs_address == 3'h4
		&& avs_writedata[3] |-> ##[1:3] txd_oe) else $error("tx pin not taken");
	chk_release_idle: assert property ($fell(txd_oe) |-> txd_out && $past(txd_out))
		else $error("tx pin released mid frame");
	chk_sclk_idle: assert property (!serial_clock_oe |-> !serial_clock_out)
		else $error("clock high while undriven");
	chk_vector_codes: assert property (irq_vector inside {8'h00, 8'h02, 8'h04})
		else $error("illegal vector offset");
endmodule : serial_port_control_and_baud_asserts

bind serial_port_control_and_baud serial_port_control_and_baud_asserts u_chk (
	.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rxd_in(rxd_in), .txd_out(txd_out),
	.txd_oe(txd_oe), .rxd_takeover(rxd_takeover), .serial_clock_out(serial_clock_out),
	.serial_clock_oe(serial_clock_oe), .irq_pending(irq_pending), .irq_vector(irq_vector)
);

// File: tb/serial_line_partner.sv
// Remote transceiver model echoing the transmit line back to the receiver
`timescale 1ns/100ps

module serial_line_partner (
	input  wire logic txd,
	input  wire logic txd_oe,
	output logic      rxd
);
	// ==================================================================
	// Loopback
	// Released line sits at its pull-up level, as an idle serial line does
	assign rxd = txd_oe ? txd : 1'b1;
endmodule : serial_line_partner

// File: tb/serial_port_control_and_baud_tb.sv
// Self-checking bench for registers, frames, SPI and vectors of the serial port
`timescale 1ns/100ps

module serial_port_control_and_baud_tb import serial_port_pkg::*;;
	// ==================================================================
	// Signals and instances
	logic        clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [2:0]  avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, rxd_in, txd_out, txd_oe, rxd_takeover;
	logic        serial_clock_out, serial_clock_oe, irq_pending;
	logic [7:0]  irq_vector;
	int          errors = 0, comparisons = 0;
	always #4 clk = ~clk;
	serial_port_control_and_baud uut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_in(rxd_in),
		.txd_out(txd_out), .txd_oe(txd_oe), .rxd_takeover(rxd_takeover),
		.serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
		.irq_pending(irq_pending), .irq_vector(irq_vector));
	serial_line_partner far_end (.txd(txd_out), .txd_oe(txd_oe), .rxd(rxd_in));
	// ==================================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask : waitc
	task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) errors++;
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		bus(a, 1'b0, 8'h00, q);
		chk(q & m, e, "read");
	endtask : rc
	// Mid-bit samples; bc is clocks per bit
	task automatic txchk(input logic [8:0] d, input int nb, input logic [1:0] par,
		input int st, input int bc);
		int n;
		logic p;
		n = 0;
		p = par[0];
		while (txd_out !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		waitc(bc / 2);
		chk(txd_out, 0, "start bit");
		for (int k = 0; k < nb; k++) begin
			waitc(bc);
			chk(txd_out, d[k], "data bit");
			p = p ^ d[k];
		end
		if (par[1]) begin
			waitc(bc);
			chk(txd_out, p, "parity bit");
		end
		for (int k = 0; k < st; k++) begin
			waitc(bc);
			chk(txd_out, 1, "stop bit");
		end
	endtask : txchk
	task automatic run(input logic [7:0] bh, bl, le, fmt, d, input int nb, bc, input logic rx);
		logic [7:0] m;
		m = (nb < 8) ? 8'((1 << nb) - 1) : 8'hff;
		wr(3'h7, bh);
		wr(3'h6, bl);
		wr(3'h5, fmt);
		wr(3'h4, le);
		wr(3'h0, d);
		txchk({le[0], d}, nb, fmt[5:4], fmt[3] + 1, bc);
		chk(serial_clock_oe, 0, "clock pin");
		waitc(3 * bc);
		rc(3'h1, 8'h9d, {rx, 6'h00, rx && nb == 9});
		if (rx) rc(3'h0, m, d & m);
	endtask : run
	task automatic spi(input logic [7:0] fmt, d);
		int n;
		logic p;
		wr(3'h5, fmt);
		wr(3'h4, 8'h18);
		wr(3'h0, d);
		for (int k = 0; k < 8; k++) begin
			n = 0;
			do begin
				p = serial_clock_out;
				@(posedge clk);
				n++;
			end while (!(serial_clock_out !== p && serial_clock_out === !fmt[1]) && n < 200);
			chk(txd_out, fmt[2] ? d[k] : d[7 - k], "spi bit");
		end
		chk(serial_clock_oe, 1, "clock pin");
		waitc(8);
		rc(3'h1, 8'h9d, 8'h80);
		rc(3'h0, 8'hff, d);
	endtask : spi
	task automatic print_verdict;
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// ==================================================================
	// Sequence
	initial begin
		waitc(8);
		resetn <= 1'b1;
		rc(3'h4, 8'hff, 8'h00);
		rc(3'h6, 8'hff, 8'h00);
		rc(3'h1, 8'h20, 8'h20);
		wr(3'h2, 8'hff);
		rc(3'h2, 8'hff, 8'h00);
		wr(3'h3, 8'h3f);
		rc(3'h3, 8'hff, 8'h3f);
		wr(3'h3, 8'h00);
		wr(3'h4, 8'h03);
		rc(3'h4, 8'hff, 8'h03);
		wr(3'h5, 8'ha5);
		rc(3'h5, 8'hff, 8'ha5);
		wr(3'h7, 8'h23);
		rc(3'h7, 8'hff, 8'h23);
		wr(3'h6, 8'h5c);
		rc(3'h6, 8'hff, 8'h5c);
		wr(3'h7, 8'h00);
		wr(3'h6, 8'h00);
		// Held byte while transmitter off; second write must be lost
		wr(3'h5, 8'h03);
		wr(3'h0, 8'h5a);
		rc(3'h1, 8'h20, 8'h00);
		wr(3'h0, 8'h11);
		wr(3'h4, 8'h08);
		txchk(9'h05a, 8, 2'b00, 1, 16);
		waitc(60);
		chk(txd_out, 1, "dropped write");
		wr(3'h0, 8'h77);
		wr(3'h4, 8'h00);
		txchk(9'h077, 8, 2'b00, 1, 16);
		waitc(16);
		chk(txd_oe, 0, "pin release");
		run(8'h00, 8'h00, 8'h18, 8'h00, 8'h15, 5, 16, 1);
		run(8'h00, 8'h00, 8'h18, 8'h2b, 8'h5b, 8, 16, 1);
		run(8'h00, 8'h00, 8'h18, 8'h33, 8'hc3, 8, 16, 1);
		run(8'h00, 8'h00, 8'h19, 8'h07, 8'h6e, 9, 16, 1);
		run(8'h00, 8'h00, 8'h1c, 8'h03, 8'h81, 8, 8, 1);
		run(8'h10, 8'h00, 8'h18, 8'h03, 8'h3c, 8, 32, 1);
		run(8'h90, 8'h00, 8'h18, 8'h03, 8'h3d, 8, 16, 1);
		run(8'h00, 8'h01, 8'h18, 8'h03, 8'h3e, 8, 32, 1);
		run(8'h00, 8'h00, 8'h1a, 8'h03, 8'h35, 8, 16, 0);
		run(8'h00, 8'h00, 8'h1a, 8'h03, 8'hb5, 8, 16, 1);
		// Unread frame raises receive vector, then disable flushes it
		wr(3'h4, 8'h18);
		wr(3'h0, 8'h42);
		txchk(9'h042, 8, 2'b00, 1, 16);
		waitc(48);
		wr(3'h3, 8'h11);
		waitc(2);
		chk(irq_pending, 1, "irq pending");
		chk(irq_vector, 8'h00, "vector");
		wr(3'h4, 8'h08);
		waitc(3);
		rc(3'h1, 8'h9d, 8'h00);
		chk(irq_vector, 8'h02, "vector");
		wr(3'h3, 8'h04);
		waitc(2);
		chk(irq_vector, 8'h04, "vector");
		wr(3'h1, 8'h40);
		waitc(2);
		chk(irq_pending, 0, "irq cleared");
		wr(3'h3, 8'h00);
		spi(8'hc0, 8'ha6);
		spi(8'hc4, 8'ha6);
		spi(8'hc2, 8'h3b);
		print_verdict();
	end
	initial begin
		waitc(40000);
		errors++;
		print_verdict();
	end
endmodule : serial_port_control_and_baud_tb
